// *** logic/ssom_mapper.v ***
// servo status output mapper: evaluates drive conditions into output
// function flags and routes them to the physical digital outputs.
// assumes one 100 MHz clock; word inputs come from the motor loops on
// that clock, one-bit condition inputs are pins and are synchronised.
//
// Function
// - any function code and mode may be mapped onto any fixed output pin
// - ready flag only when drive ready to run and no fault or caution
// - power on flag follows control power, ignores faults, does not mean ready
// - low speed flag while speed at or below zero speed threshold
// - speed reached flag while speed at or above target speed setting
// - pulse train mode: position reached when error at most the window
// - preset mode: position reached within minus to plus window, default 99
// - torque limit flag when torque hits register limit or analog limit
// - fault flag whenever any fault condition is detected
// - listed limit, stop, link and undervoltage faults raise caution first
// - caution flag on limits, emergency stop, link error or undervoltage
// - brake release flag asserts to actuate the motor brake
// - homing done after home sensor seen and homing conditions satisfied
// - overload warning when load reaches the overload level setting
// - preset mode: move done after command completes and delay elapses
// - active level of each output set on or off by configuration
`timescale 1ns/1ns
`include "ssom_regs.vh"

module ssom_mapper #(
   parameter NUM_DO = 5,
   parameter MS_CYCLES = `SSOM_MS_CYCLES
) (
   input wire clock,
   input wire rst_b,
   // avalon-mm slave
   input wire [7:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   // word conditions from the motor loops (same clock)
   input wire [15:0] motor_speed_abs,
   input wire [15:0] pos_error_abs,
   input wire [31:0] pos_deviation,
   input wire [15:0] motor_torque_abs,
   input wire [15:0] motor_load_level,
   // one-bit conditions (pins)
   input wire control_power,
   input wire drive_ok,
   input wire other_fault,
   input wire limit_rev,
   input wire limit_fwd,
   input wire estop,
   input wire comm_error,
   input wire undervoltage,
   input wire ext_torque_limit,
   input wire brake_cmd,
   input wire home_sensor,
   input wire homing_cond_ok,
   input wire cmd_complete,
   // physical outputs and flags
   output reg [NUM_DO-1:0] do_out,
   output reg [12:1] fn_flags
);

   // ***************************************************************
   // pin synchronisers
   // ***************************************************************
   localparam NSYNC = 13;
   wire [NSYNC-1:0] pin_raw;
   reg [NSYNC-1:0] sync1_reg;
   reg [NSYNC-1:0] sync2_reg;

   assign pin_raw = {cmd_complete, homing_cond_ok, home_sensor, brake_cmd,
      ext_torque_limit, undervoltage, comm_error, estop, limit_fwd,
      limit_rev, other_fault, drive_ok, control_power};

   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sync1_reg <= {NSYNC{1'b0}};
         sync2_reg <= {NSYNC{1'b0}};
      end else begin
         sync1_reg <= pin_raw;
         sync2_reg <= sync1_reg;
      end
   end

   wire s_power = sync2_reg[0];
   wire s_drive_ok = sync2_reg[1];
   wire s_other_fault = sync2_reg[2];
   wire [4:0] s_caution_src = sync2_reg[7:3];
   wire s_ext_trq = sync2_reg[8];
   wire s_brake = sync2_reg[9];
   wire s_home = sync2_reg[10];
   wire s_home_ok = sync2_reg[11];
   wire s_cmd_done = sync2_reg[12];

   // ***************************************************************
   // registers
   // ***************************************************************
   reg [15:0] zero_thr_reg;
   reg [15:0] tgt_spd_reg;
   reg [15:0] pos_win_reg;
   reg [15:0] trq_lim_reg;
   reg [15:0] ovl_level_reg;
   reg [15:0] done_dly_reg;
   reg preset_mode_reg;
   reg [4*NUM_DO-1:0] do_map_reg;
   reg [NUM_DO-1:0] do_sense_reg;
   reg home_clr_pulse;

   wire wr_go = avs_write & ~avs_waitrequest;
   wire [31:0] wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   // lane masks cut to the width of each register
   wire [15:0] wm16 = wmask[15:0];
   wire [15:0] wd16 = avs_writedata[15:0];
   wire [4*NUM_DO-1:0] wm_map = wmask[4*NUM_DO-1:0];
   wire [NUM_DO-1:0] wm_sense = wmask[NUM_DO-1:0];

   // waitrequest drops for one cycle, one edge after the request appears
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         avs_waitrequest <= 1'b1;
      end else if ((avs_read | avs_write) & avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         zero_thr_reg <= `SSOM_RST_ZERO_THR;
         tgt_spd_reg <= `SSOM_RST_TGT_SPD;
         pos_win_reg <= `SSOM_RST_POS_WIN;
         trq_lim_reg <= `SSOM_RST_TRQ_LIM;
         ovl_level_reg <= `SSOM_RST_OVL_LEVEL;
         done_dly_reg <= `SSOM_RST_DONE_DLY;
         preset_mode_reg <= 1'b0;
         do_map_reg <= `SSOM_RST_DO_MAP;
         do_sense_reg <= `SSOM_RST_DO_SENSE;
         home_clr_pulse <= 1'b0;
      end else begin
         home_clr_pulse <= 1'b0;
         if (wr_go) begin
            case (avs_address)
               `SSOM_ADDR_ZERO_THR: zero_thr_reg <=
                  (zero_thr_reg & ~wm16) | (wd16 & wm16);
               `SSOM_ADDR_TGT_SPD: tgt_spd_reg <=
                  (tgt_spd_reg & ~wm16) | (wd16 & wm16);
               `SSOM_ADDR_POS_WIN: pos_win_reg <=
                  (pos_win_reg & ~wm16) | (wd16 & wm16);
               `SSOM_ADDR_TRQ_LIM: trq_lim_reg <=
                  (trq_lim_reg & ~wm16) | (wd16 & wm16);
               `SSOM_ADDR_OVL_LEVEL: ovl_level_reg <=
                  (ovl_level_reg & ~wm16) | (wd16 & wm16);
               `SSOM_ADDR_DONE_DLY: done_dly_reg <=
                  (done_dly_reg & ~wm16) | (wd16 & wm16);
               `SSOM_ADDR_CTRL: begin
                  if (avs_byteenable[0]) begin
                     preset_mode_reg <=
                        avs_writedata[`SSOM_CTRL_PRESET_BIT];
                     home_clr_pulse <=
                        avs_writedata[`SSOM_CTRL_HOME_CLR_BIT];
                  end
               end
               `SSOM_ADDR_DO_MAP: do_map_reg <=
                  (do_map_reg & ~wm_map) |
                  (avs_writedata[4*NUM_DO-1:0] & wm_map);
               `SSOM_ADDR_DO_SENSE: do_sense_reg <=
                  (do_sense_reg & ~wm_sense) |
                  (avs_writedata[NUM_DO-1:0] & wm_sense);
               default: ;
            endcase
         end
      end
   end

   // read data is loaded on the same edge that lowers waitrequest
   reg [31:0] rd_next;
   always @* begin
      rd_next = 32'h00000000;
      case (avs_address)
         `SSOM_ADDR_ZERO_THR: rd_next = {16'h0000, zero_thr_reg};
         `SSOM_ADDR_TGT_SPD: rd_next = {16'h0000, tgt_spd_reg};
         `SSOM_ADDR_POS_WIN: rd_next = {16'h0000, pos_win_reg};
         `SSOM_ADDR_TRQ_LIM: rd_next = {16'h0000, trq_lim_reg};
         `SSOM_ADDR_OVL_LEVEL: rd_next = {16'h0000, ovl_level_reg};
         `SSOM_ADDR_DONE_DLY: rd_next = {16'h0000, done_dly_reg};
         `SSOM_ADDR_CTRL: rd_next = {31'h00000000, preset_mode_reg};
         `SSOM_ADDR_DO_MAP:
            rd_next = {{(32-4*NUM_DO){1'b0}}, do_map_reg};
         `SSOM_ADDR_DO_SENSE:
            rd_next = {{(32-NUM_DO){1'b0}}, do_sense_reg};
         `SSOM_ADDR_STATUS: rd_next = {19'h00000, fn_flags, 1'b0};
         default: rd_next = 32'h00000000;
      endcase
   end

   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read & avs_waitrequest) begin
         avs_readdata <= rd_next;
      end
   end

   // ***************************************************************
   // position window checks
   // ***************************************************************
   wire signed [31:0] dev_s = pos_deviation;
   wire signed [31:0] win_pos = {16'h0000, pos_win_reg};
   wire signed [31:0] win_neg = -win_pos;
   wire in_band = (dev_s >= win_neg) && (dev_s <= win_pos);
   wire err_ok = pos_error_abs <= pos_win_reg;

   // ***************************************************************
   // homing and move completion
   // ***************************************************************
   reg homed_reg;
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         homed_reg <= 1'b0;
      end else if (s_home & s_home_ok) begin
         homed_reg <= 1'b1;
      end else if (home_clr_pulse) begin
         homed_reg <= 1'b0;
      end
   end

   reg [31:0] tick_cnt_reg;
   reg [15:0] ms_cnt_reg;
   reg move_done_reg;
   wire tick = (tick_cnt_reg == MS_CYCLES - 1);
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         tick_cnt_reg <= 32'h00000000;
         ms_cnt_reg <= 16'h0000;
         move_done_reg <= 1'b0;
      end else if (!(preset_mode_reg & s_cmd_done)) begin
         tick_cnt_reg <= 32'h00000000;
         ms_cnt_reg <= 16'h0000;
         move_done_reg <= 1'b0;
      end else if (ms_cnt_reg >= done_dly_reg) begin
         move_done_reg <= 1'b1;
      end else if (tick) begin
         tick_cnt_reg <= 32'h00000000;
         ms_cnt_reg <= ms_cnt_reg + 16'h0001;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
      end
   end

   // ***************************************************************
   // function flags
   // ***************************************************************
   wire caution_now = |s_caution_src;
   reg [12:1] fn_next;
   always @* begin
      fn_next = 12'h000;
      fn_next[`SSOM_FN_CAUTION] = caution_now;
      // caution-class faults reach the fault flag one cycle after caution
      fn_next[`SSOM_FN_FAULT] = s_other_fault |
         fn_flags[`SSOM_FN_CAUTION];
      // a one-cycle caution still blocks ready while it turns into fault
      fn_next[`SSOM_FN_READY] = s_power & s_drive_ok & ~s_other_fault &
         ~caution_now & ~fn_flags[`SSOM_FN_CAUTION] &
         ~fn_flags[`SSOM_FN_FAULT];
      fn_next[`SSOM_FN_POWER] = s_power;
      fn_next[`SSOM_FN_LOWSPD] = motor_speed_abs <= zero_thr_reg;
      fn_next[`SSOM_FN_SPDREACH] = motor_speed_abs >= tgt_spd_reg;
      fn_next[`SSOM_FN_POSREACH] = preset_mode_reg ? in_band : err_ok;
      fn_next[`SSOM_FN_TRQLIM] = (motor_torque_abs >= trq_lim_reg) |
         s_ext_trq;
      fn_next[`SSOM_FN_BRAKE] = s_brake;
      fn_next[`SSOM_FN_HOMED] = homed_reg;
      fn_next[`SSOM_FN_OVLWARN] = motor_load_level >= ovl_level_reg;
      fn_next[`SSOM_FN_MOVEDONE] = move_done_reg;
   end

   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         fn_flags <= 12'h000;
      end else begin
         fn_flags <= fn_next;
      end
   end

   // ***************************************************************
   // output routing
   // ***************************************************************
   wire [13:0] fn_vec = {1'b0, fn_flags, 1'b0};
   genvar gi;
   generate
      for (gi = 0; gi < NUM_DO; gi = gi + 1) begin : g_do
         wire [3:0] code = do_map_reg[4*gi+3:4*gi];
         wire act = (code > `SSOM_FN_MOVEDONE) ? 1'b0 : fn_vec[code];
         always @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
               do_out[gi] <= 1'b0;
            end else begin
               do_out[gi] <= act ^ do_sense_reg[gi];
            end
         end
      end
   endgenerate

endmodule // ssom_mapper

// *** include/ssom_regs.vh ***
// register offsets, field positions, reset values and timing counts
// of the servo status output mapper; included by the design file and the testbench
`ifndef SSOM_REGS_VH
`define SSOM_REGS_VH

// ***************************************************************
// register byte offsets (word aligned)
// ***************************************************************
`define SSOM_ADDR_ZERO_THR 8'h00
`define SSOM_ADDR_TGT_SPD 8'h04
`define SSOM_ADDR_POS_WIN 8'h08
`define SSOM_ADDR_TRQ_LIM 8'h0C
`define SSOM_ADDR_OVL_LEVEL 8'h10
`define SSOM_ADDR_DONE_DLY 8'h14
`define SSOM_ADDR_CTRL 8'h18
`define SSOM_ADDR_DO_MAP 8'h1C
`define SSOM_ADDR_DO_SENSE 8'h20
`define SSOM_ADDR_STATUS 8'h24

// ***************************************************************
// reset values
// ***************************************************************
`define SSOM_RST_ZERO_THR 16'h000A
`define SSOM_RST_TGT_SPD 16'h0BB8
`define SSOM_RST_POS_WIN 16'h0063
`define SSOM_RST_TRQ_LIM 16'hFFFF
`define SSOM_RST_OVL_LEVEL 16'hFFFF
`define SSOM_RST_DONE_DLY 16'h0000
`define SSOM_RST_CTRL 2'h0
`define SSOM_RST_DO_MAP 20'h87431
`define SSOM_RST_DO_SENSE 5'h00

// ***************************************************************
// control register fields
// ***************************************************************
`define SSOM_CTRL_PRESET_BIT 0
`define SSOM_CTRL_HOME_CLR_BIT 1

// ***************************************************************
// output function codes
// ***************************************************************
`define SSOM_FN_OFF 4'h0
`define SSOM_FN_READY 4'h1
`define SSOM_FN_POWER 4'h2
`define SSOM_FN_LOWSPD 4'h3
`define SSOM_FN_SPDREACH 4'h4
`define SSOM_FN_POSREACH 4'h5
`define SSOM_FN_TRQLIM 4'h6
`define SSOM_FN_FAULT 4'h7
`define SSOM_FN_BRAKE 4'h8
`define SSOM_FN_HOMED 4'h9
`define SSOM_FN_OVLWARN 4'hA
`define SSOM_FN_CAUTION 4'hB
`define SSOM_FN_MOVEDONE 4'hC

// ***************************************************************
// timing: completion delay is counted in milliseconds
// ***************************************************************
`define SSOM_CLK_PERIOD_NS 10
`define SSOM_DELAY_UNIT_MS 1
`define SSOM_MS_CYCLES ((`SSOM_DELAY_UNIT_MS * 1000000) / `SSOM_CLK_PERIOD_NS)

`endif

// *** verif/ssom_chk.sv ***
// assertions on the status output mapper ports: bus handshake and flags
// assumes one clock domain and the async active-low reset rst_b
`timescale 1ns/1ns
module ssom_chk (
   input wire clock,
   input wire rst_b,
   input wire avs_read,
   input wire avs_write,
   input wire avs_waitrequest,
   input wire control_power,
   input wire ext_torque_limit,
   input wire brake_cmd,
   input wire [12:1] fn_flags
);
// ***************************************************************
// properties
// ***************************************************************
default clocking @(posedge clock); endclocking
default disable iff (!rst_b);
a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
   |=> !avs_waitrequest) else $error("bus request not answered in one cycle");
a_bus_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
   else $error("waitrequest low for more than one cycle");
a_power_follows: assert property (control_power [*4] |-> fn_flags[2])
   else $error("power on flag missing while power applied");
a_power_drops: assert property (!control_power [*4] |-> !fn_flags[2])
   else $error("power on flag set without power");
a_fault_after_caution: assert property (fn_flags[11] |=> fn_flags[7])
   else $error("fault flag did not follow caution flag");
a_ready_blocked: assert property (fn_flags[7] || fn_flags[11] |-> !fn_flags[1])
   else $error("ready flag set during fault or caution");
a_ready_power: assert property (fn_flags[1] |-> fn_flags[2])
   else $error("ready flag set without power on flag");
a_torque_pin: assert property (ext_torque_limit [*4] |-> fn_flags[6])
   else $error("torque limit flag missing on external limit");
a_brake_follows: assert property (brake_cmd [*4] |-> fn_flags[8])
   else $error("brake release flag missing");
a_homed_sticky: assert property (fn_flags[9] && !avs_write && !$past(avs_write)
   && !$past(avs_write, 2) |=> fn_flags[9]) else $error("homing done flag lost");
endmodule // ssom_chk

bind ssom_mapper ssom_chk u_chk (.clock(clock), .rst_b(rst_b),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .control_power(control_power),
   .ext_torque_limit(ext_torque_limit), .brake_cmd(brake_cmd),
   .fn_flags(fn_flags));

// *** verif/ssom_ctrl_model.sv ***
// external controller model: samples the drive's digital outputs
// assumes the drive's clock and reset; outputs are level signals
`timescale 1ns/1ns
module ssom_ctrl_model (
   input wire clock,
   input wire rst_b,
   input wire [4:0] do_out,
   output reg [4:0] do_seen
);
// ***************************************************************
// sampling
// ***************************************************************
always @(posedge clock or negedge rst_b) begin
   if (!rst_b)
      do_seen <= 5'h00;
   else
      do_seen <= do_out;
end
endmodule // ssom_ctrl_model

// *** verif/servo_status_output_mapper_test.sv ***
// testbench of the status output mapper: bus tasks and flag scenarios
// assumes ssom_mapper, ssom_ctrl_model and the bound checker
`timescale 1ns/1ns
`include "ssom_regs.vh"
module servo_status_output_mapper_test;
reg clock, rst_b, avs_read, avs_write;
reg [7:0] avs_address;
reg [31:0] avs_writedata, rd;
reg [15:0] spd, perr, trq, load;
reg [31:0] pdev;
reg [12:0] pin;
reg [3:0] be;
wire [31:0] avs_readdata;
wire avs_waitrequest;
wire [4:0] do_out, do_seen;
wire [12:1] fn_flags;
integer failures, compares, i;
reg [15:0] sv [4] = '{16'h000A, 16'h000B, 16'h0BB7, 16'h0BB8};
reg [1:0] ex [4] = '{2'h1, 2'h0, 2'h0, 2'h2};

ssom_mapper #(.NUM_DO(5), .MS_CYCLES(10)) dut (.clock(clock), .rst_b(rst_b),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(be),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .motor_speed_abs(spd), .pos_error_abs(perr), .pos_deviation(pdev),
   .motor_torque_abs(trq), .motor_load_level(load),
   .control_power(pin[0]), .drive_ok(pin[1]), .other_fault(pin[2]),
   .limit_rev(pin[3]), .limit_fwd(pin[4]), .estop(pin[5]),
   .comm_error(pin[6]), .undervoltage(pin[7]), .ext_torque_limit(pin[8]),
   .brake_cmd(pin[9]), .home_sensor(pin[10]), .homing_cond_ok(pin[11]),
   .cmd_complete(pin[12]), .do_out(do_out), .fn_flags(fn_flags));
ssom_ctrl_model ctrl (.clock(clock), .rst_b(rst_b), .do_out(do_out),
   .do_seen(do_seen));

initial begin
   clock = 1'b0;
   forever #5 clock = ~clock;
end

// ***************************************************************
// tasks
// ***************************************************************
task print_verdict;
   begin
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
endtask

task chk(input [31:0] s, input [31:0] e, input [8*10-1:0] n);
   begin
      compares = compares + 1;
      if (s !== e) begin
         $display("CHECK FAILED %0s exp %h seen %h", n, e, s);
         failures = failures + 1;
      end
   end
endtask

task step(input integer n);
   repeat (n) @(posedge clock);
endtask

// one avalon access; held until waitrequest is sampled low
task rw(input r, input [7:0] a, input [31:0] wd);
   integer n;
   begin
      @(posedge clock);
      avs_address <= a;
      avs_read <= r;
      avs_write <= !r;
      avs_writedata <= wd;
      n = 0;
      do begin
         @(posedge clock);
         n = n + 1;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (avs_waitrequest !== 1'b0) begin
         failures = failures + 1;
         print_verdict;
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   end
endtask

// ***************************************************************
// scenarios
// ***************************************************************
initial begin
   rst_b = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 8'h00;
   avs_writedata = 32'h0; spd = 16'h0; perr = 16'h0; pdev = 32'h0;
   trq = 16'h0; load = 16'h0; pin = 13'h0; failures = 0; compares = 0;
   be = 4'hF;
   repeat (16) @(posedge clock);
   rst_b <= 1'b1;
   rw(1, `SSOM_ADDR_DO_MAP, 0); chk(rd, 32'h87431, "do_map");
   rw(1, `SSOM_ADDR_POS_WIN, 0); chk(rd, 32'h63, "pos_win");
   rw(1, `SSOM_ADDR_ZERO_THR, 0); chk(rd, 32'hA, "zero_thr");
   be <= 4'h1; rw(0, `SSOM_ADDR_ZERO_THR, 32'h1234); be <= 4'hF;
   rw(1, `SSOM_ADDR_ZERO_THR, 0); chk(rd, 32'h34, "zero_lane");
   rw(0, `SSOM_ADDR_ZERO_THR, 32'hA);
   rw(0, 8'h28, 32'hFFFF); rw(1, 8'h28, 0); chk(rd, 32'h0, "unmapped");
   for (i = 0; i < 4; i = i + 1) begin
      spd <= sv[i];
      step(2);
      chk(fn_flags[4:3], ex[i], "speed");
   end
   perr <= 16'h0063; step(2); chk(fn_flags[5], 1, "pos_train");
   perr <= 16'h0064; step(2); chk(fn_flags[5], 0, "pos_train");
   rw(0, `SSOM_ADDR_CTRL, 32'h1);
   pdev <= 32'hFFFFFF9D; step(2); chk(fn_flags[5], 1, "pos_band");
   pdev <= 32'hFFFFFF9C; step(2); chk(fn_flags[5], 0, "pos_band");
   pdev <= 32'h00000063; step(2); chk(fn_flags[5], 1, "pos_band");
   rw(0, `SSOM_ADDR_TRQ_LIM, 32'h1F4); rw(0, `SSOM_ADDR_OVL_LEVEL, 32'hC8);
   trq <= 16'h01F4; load <= 16'h00C8; step(2);
   chk({fn_flags[10], fn_flags[6]}, 2'h3, "trq_ovl");
   trq <= 16'h01F3; load <= 16'h00C7; step(2);
   chk({fn_flags[10], fn_flags[6]}, 2'h0, "trq_ovl");
   pin <= 13'h0100; step(5); chk(fn_flags[6], 1, "trq_pin");
   pin <= 13'h0003; step(5); chk(fn_flags[2:1], 2'h3, "ready");
   pin <= 13'h0007; step(5); chk(fn_flags[2:1], 2'h2, "ready");
   chk({fn_flags[11], fn_flags[7]}, 2'h1, "fault");
   for (i = 3; i < 8; i = i + 1) begin
      pin <= 13'h0003 | (13'h1 << i); step(4);
      chk({fn_flags[11], fn_flags[7], fn_flags[1]}, 3'h4, "caution");
      step(1); chk({fn_flags[11], fn_flags[7]}, 2'h3, "caution");
      pin <= 13'h0003; step(6);
   end
   pin <= 13'h0203; step(6); chk(fn_flags[8], 1, "brake");
   chk(do_seen, 5'h15, "do_dflt");
   rw(0, `SSOM_ADDR_DO_MAP, 32'h200D0); rw(0, `SSOM_ADDR_DO_SENSE, 32'h03);
   step(4); chk(do_seen, 5'h13, "do_remap");
   rw(0, `SSOM_ADDR_DO_SENSE, 32'h13); step(4); chk(do_seen, 5'h03, "do_sense");
   pin <= 13'h0C03; step(5); chk(fn_flags[9], 1, "homed");
   pin <= 13'h0003; step(5); chk(fn_flags[9], 1, "homed");
   rw(0, `SSOM_ADDR_CTRL, 32'h3); step(3); chk(fn_flags[9], 0, "homed");
   pin <= 13'h0403; step(5); chk(fn_flags[9], 0, "homed");
   rw(0, `SSOM_ADDR_DONE_DLY, 32'h2);
   pin <= 13'h1003; step(10); chk(fn_flags[12], 0, "movedone");
   step(30); chk(fn_flags[12], 1, "movedone");
   pin <= 13'h0003; step(5); chk(fn_flags[12], 0, "movedone");
   rw(0, `SSOM_ADDR_CTRL, 32'h0);
   pin <= 13'h1003; step(40); chk(fn_flags[12], 0, "movedone");
   rw(0, `SSOM_ADDR_STATUS, 32'hFFFF); rw(1, `SSOM_ADDR_STATUS, 0);
   chk(rd, 32'h16, "status");
   print_verdict;
end
endmodule // servo_status_output_mapper_test
